// file: inc/plc_pkg.sv
// Package: register map, field positions, reset values and wait counts
`default_nettype none
package plc_pkg;
    // Register byte addresses on the Wishbone bus
    localparam logic [31:0] ADR_MODE_SEL = 32'hFFFF_F820;
    localparam logic [31:0] ADR_LOCK = 32'hFFFF_F824;
    localparam logic [31:0] ADR_CONTROL = 32'hFFFF_F828;
    localparam logic [31:0] ADR_LOCKUP = 32'hFFFF_F82C;
    localparam logic [31:0] ADR_STATUS = 32'hFFFF_F830;

    // Field positions
    localparam int LOCK_BIT = 0;
    localparam int STOP_SEL_BIT = 0;
    localparam int STANDBY_EN_BIT = 1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_TB_WAIT_BIT = 3;

    // Reset values
    localparam logic STOP_SEL_RST = 1'h0;
    localparam logic [15:0] LOCKUP_EXTRA_RST = 16'h0800;

    // Wait counts in clk_i cycles
    localparam int CNT_W = 16;
    localparam logic [15:0] TB_WAIT_CYC = 16'h0400;

    // Power save states
    typedef enum logic [2:0] {
        PLC_NORMAL,
        PLC_HALT,
        PLC_IDLE,
        PLC_STOP,
        PLC_TB_WAIT
    } plc_state_t;
endpackage
`default_nettype wire

// file: core/plc_wait_counter.sv
// Down counter that times one wait interval after a start pulse
`default_nettype none
module plc_wait_counter #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [W-1:0] load_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start_i) begin
            // A zero load still waits one cycle
            cnt_nxt = (load_i == '0) ? W'(1) : load_i;
            busy_nxt = 1'b1;
        end else if (abort_i) begin
            busy_nxt = 1'b0;
        end else if (busy_r) begin
            if (cnt_r == W'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;
endmodule // plc_wait_counter
`default_nettype wire

// file: core/plc_clock_ctrl.sv
// Clock generator control: lock flag, power save modes, Wishbone slave
// Functional notes
// - Lock register bit 0 shows PLL lock
// - Lock register read-only; writes ignored
// - Lock flag 0 locked, 1 unlocked
// - Standby unlock sets lock flag
// - Other unlock causes leave lock flag
// - System reset leaves lock flag alone
// - Lockup always outlasts oscillator stabilization
// - HALT stops only the CPU clock
// - HALT entered only by halt instruction
// - IDLE stops CPU and peripheral clocks
// - IDLE release needs no stabilization wait
// - IDLE or STOP chosen by mode register
// - STOP halts oscillator, PLL, every clock
// - PLL mode STOP waits time base
// - Direct mode STOP release waits time base
// - Clock enables follow mode and source
// - Select bit 0 IDLE, 1 STOP
// - Selection acts only with standby enable
//
// Design decision made here: the Wishbone register port.
`default_nettype none
module plc_clock_ctrl #(
    parameter logic [15:0] TB_WAIT = plc_pkg::TB_WAIT_CYC,
    parameter logic [15:0] LOCKUP_EXTRA = plc_pkg::LOCKUP_EXTRA_RST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic pll_mode_i,
    input wire logic ext_clk_i,
    input wire logic halt_instr_i,
    input wire logic wake_i,
    output logic osc_en_o,
    output logic pll_en_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o
);
    localparam int LW = plc_pkg::CNT_W + 1;

    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] r);
        hit = (a == r);
    endfunction

    // Bus state
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic wr_go;
    logic wr_lane0;

    // Software registers
    logic stop_sel_r;
    logic stop_sel_nxt;
    logic [15:0] extra_r;
    logic [15:0] extra_nxt;
    logic standby_req;

    // Mode and clock enables
    plc_pkg::plc_state_t state_r;
    plc_pkg::plc_state_t state_nxt;
    logic osc_r;
    logic osc_nxt;
    logic pll_r;
    logic pll_nxt;
    logic cpu_r;
    logic cpu_nxt;
    logic per_r;
    logic per_nxt;

    // Lock tracking
    logic lock_r;
    logic lock_nxt;
    logic stop_enter;
    logic stop_leave;
    logic tb_busy;
    logic tb_done;
    logic lk_done;
    logic [LW-1:0] lk_load;
    logic [15:0] extra_eff;

    // Writes take effect on the edge at which the master sees ack, so
    // a request dropped before its answer never lands
    assign wr_go = cyc_i && stb_i && we_i && ack_r;
    assign wr_lane0 = wr_go && sel_i[0];

    always_comb begin
        ack_nxt = cyc_i && stb_i && !ack_r;
        dat_nxt = 32'h0000_0000;
        if (cyc_i && stb_i && !we_i && !ack_r) begin
            if (hit(adr_i, plc_pkg::ADR_MODE_SEL)) begin
                dat_nxt[plc_pkg::STOP_SEL_BIT] = stop_sel_r;
            end else if (hit(adr_i, plc_pkg::ADR_LOCK)) begin
                dat_nxt[plc_pkg::LOCK_BIT] = lock_r;
            end else if (hit(adr_i, plc_pkg::ADR_CONTROL)) begin
                dat_nxt[plc_pkg::STANDBY_EN_BIT] =
                    (state_r == plc_pkg::PLC_IDLE) ||
                    (state_r == plc_pkg::PLC_STOP);
            end else if (hit(adr_i, plc_pkg::ADR_LOCKUP)) begin
                dat_nxt[15:0] = extra_r;
            end else if (hit(adr_i, plc_pkg::ADR_STATUS)) begin
                dat_nxt[plc_pkg::ST_MODE_LSB +: 3] = state_r;
                dat_nxt[plc_pkg::ST_TB_WAIT_BIT] = tb_busy;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Only the low byte lane holds register bits, except the lockup extra count, which uses lanes 0 and 1
    always_comb begin
        stop_sel_nxt = stop_sel_r;
        extra_nxt = extra_r;
        if (wr_lane0 && hit(adr_i, plc_pkg::ADR_MODE_SEL)) begin
            stop_sel_nxt = dat_i[plc_pkg::STOP_SEL_BIT];
        end
        if (wr_go && hit(adr_i, plc_pkg::ADR_LOCKUP)) begin
            if (sel_i[0]) begin
                extra_nxt[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
                extra_nxt[15:8] = dat_i[15:8];
            end
        end
        // Writes to the lock register fall through untouched
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_sel_r <= plc_pkg::STOP_SEL_RST;
            extra_r <= LOCKUP_EXTRA;
        end else begin
            stop_sel_r <= stop_sel_nxt;
            extra_r <= extra_nxt;
        end
    end

    // Standby enable written as 1 is the only way into IDLE or STOP
    assign standby_req = wr_lane0 && hit(adr_i, plc_pkg::ADR_CONTROL) &&
                         dat_i[plc_pkg::STANDBY_EN_BIT];

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            plc_pkg::PLC_NORMAL: begin
                if (standby_req) begin
                    state_nxt = stop_sel_r ? plc_pkg::PLC_STOP
                                           : plc_pkg::PLC_IDLE;
                end else if (halt_instr_i) begin
                    state_nxt = plc_pkg::PLC_HALT;
                end
            end
            plc_pkg::PLC_HALT: begin
                if (wake_i) begin
                    state_nxt = plc_pkg::PLC_NORMAL;
                end
            end
            plc_pkg::PLC_IDLE: begin
                if (wake_i) begin
                    state_nxt = plc_pkg::PLC_NORMAL;
                end
            end
            plc_pkg::PLC_STOP: begin
                if (wake_i) begin
                    state_nxt = plc_pkg::PLC_TB_WAIT;
                end
            end
            plc_pkg::PLC_TB_WAIT: begin
                // Execution resumes only after the time base count
                if (tb_done) begin
                    state_nxt = plc_pkg::PLC_NORMAL;
                end
            end
        endcase
    end

    // Enables follow the next state so each output is a plain flop
    always_comb begin
        osc_nxt = !ext_clk_i &&
                  (state_nxt != plc_pkg::PLC_STOP);
        pll_nxt = pll_mode_i &&
                  (state_nxt != plc_pkg::PLC_STOP);
        cpu_nxt = (state_nxt == plc_pkg::PLC_NORMAL);
        per_nxt = (state_nxt == plc_pkg::PLC_NORMAL) ||
                  (state_nxt == plc_pkg::PLC_HALT);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= plc_pkg::PLC_NORMAL;
            osc_r <= 1'b0;
            pll_r <= 1'b0;
            cpu_r <= 1'b1;
            per_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            osc_r <= osc_nxt;
            pll_r <= pll_nxt;
            cpu_r <= cpu_nxt;
            per_r <= per_nxt;
        end
    end

    assign stop_enter = (state_r != plc_pkg::PLC_STOP) &&
                        (state_nxt == plc_pkg::PLC_STOP);
    assign stop_leave = (state_r == plc_pkg::PLC_STOP) &&
                        (state_nxt == plc_pkg::PLC_TB_WAIT);

    // Lockup spans the time base wait plus a nonzero extra, so it is
    // always the longer of the two intervals
    assign extra_eff = (extra_r == 16'h0000) ? 16'h0001 : extra_r;
    assign lk_load = LW'(TB_WAIT) + LW'(extra_eff);

    plc_wait_counter #(
        .W(plc_pkg::CNT_W)
    ) u_tb_wait (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(stop_leave),
        .abort_i(1'b0),
        .load_i(TB_WAIT),
        .busy_o(tb_busy),
        .done_o(tb_done)
    );

    // Lockup timing starts on power-on and STOP release only; system reset must not
    // restart it or the flag would lie about a running PLL
    plc_wait_counter #(
        .W(LW)
    ) u_lockup (
        .clk_i(clk_i),
        .rst_i(1'b0),
        .start_i(por_i || stop_leave),
        .abort_i(stop_enter),
        .load_i(lk_load),
        .busy_o(),
        .done_o(lk_done)
    );

    // Set beats clear; only power-on and STOP entry in PLL mode raise the flag,
    // so a loss of lock from any other cause leaves it at 0
    always_comb begin
        lock_nxt = lock_r;
        if (lk_done) begin
            lock_nxt = 1'b0;
        end
        if (por_i || (stop_enter && pll_mode_i)) begin
            lock_nxt = 1'b1;
        end
    end

    // No system reset branch: the flag survives rst_i
    always_ff @(posedge clk_i) begin
        lock_r <= lock_nxt;
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign osc_en_o = osc_r;
    assign pll_en_o = pll_r;
    assign cpu_clk_en_o = cpu_r;
    assign periph_clk_en_o = per_r;
endmodule // plc_clock_ctrl
`default_nettype wire

// file: testbench/plc_clock_ctrl_sva.sv
// Checker: bus answer, clock enables and time base wait
`default_nettype none
module plc_clock_ctrl_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] adr_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic pll_mode_i,
    input wire logic ext_clk_i,
    input wire logic halt_instr_i,
    input wire logic osc_en_o,
    input wire logic pll_en_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    // Time base wait is shortened to 8 cycles in the bench
    sequence s_tb_wait;
        !cpu_clk_en_o [*8] ##[1:3] cpu_clk_en_o;
    endsequence
    ack_once_a: assert property (s_req |=> ack_o ##1 !ack_o)
        else $error("bus answer wrong");
    lock_upper_a: assert property (s_req ##0 (adr_i == plc_pkg::ADR_LOCK &&
        !we_i) |=> dat_o[31:1] == 31'h0) else $error("lock upper bits set");
    cpu_periph_a: assert property (cpu_clk_en_o |-> periph_clk_en_o)
        else $error("cpu clock without peripheral clock");
    halt_cause_a: assert property ($fell(cpu_clk_en_o) && periph_clk_en_o
        |-> $past(halt_instr_i)) else $error("halt without instruction");
    ext_osc_a: assert property (ext_clk_i && $past(ext_clk_i)
        |-> !osc_en_o) else $error("oscillator runs on external clock");
    direct_pll_a: assert property (!pll_mode_i && !$past(pll_mode_i)
        |-> !pll_en_o) else $error("pll runs in direct mode");
    stop_all_a: assert property (pll_mode_i && $past(pll_mode_i) &&
        !$past(rst_i, 2) && !pll_en_o |-> !cpu_clk_en_o && !periph_clk_en_o
        && !osc_en_o) else $error("clock runs with pll stopped");
    stop_wait_a: assert property ($rose(pll_en_o) && !cpu_clk_en_o
        |-> s_tb_wait) else $error("time base wait wrong");
endmodule // plc_clock_ctrl_sva
bind plc_clock_ctrl plc_clock_ctrl_sva u_sva (.clk_i, .rst_i, .adr_i, .we_i,
    .cyc_i, .stb_i, .dat_o, .ack_o, .pll_mode_i, .ext_clk_i, .halt_instr_i,
    .osc_en_o, .pll_en_o, .cpu_clk_en_o, .periph_clk_en_o);
`default_nettype wire

// file: testbench/plc_core_model.sv
// Core model: runs the halt instruction only while its clock runs
`default_nettype none
module plc_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cpu_clk_en_i,
    input wire logic halt_req_i,
    output logic halt_instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend_r;
    logic pend_nxt;
    logic halt_nxt;
    always_comb begin
        // A stopped core executes nothing, so a request waits
        pend_nxt = pend_r | halt_req_i;
        halt_nxt = 1'b0;
        if (pend_nxt && cpu_clk_en_i) begin
            halt_nxt = 1'b1;
            pend_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        pend_r <= rst_i ? 1'b0 : pend_nxt;
        halt_instr_o <= rst_i ? 1'b0 : halt_nxt;
    end
endmodule // plc_core_model
`default_nettype wire

// file: testbench/tb_plc_clock_ctrl.sv
// Testbench: lock flag, power save modes and register access
`default_nettype none
module tb_plc_clock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TBW = 8;
    logic clk_i = 0, rst_i = 1, por_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic pll_mode_i = 1, ext_clk_i = 0, wake_i = 0, halt_req = 0;
    logic [31:0] adr_i = 0, dat_i = 0, dat_o;
    logic [3:0] sel_i = 0;
    logic ack_o, halt_instr_i, osc_en_o, pll_en_o, cpu_clk_en_o;
    logic periph_clk_en_o;
    int n_errors = 0, num_checks = 0, cyc_cnt = 0;
    always #5 clk_i = ~clk_i;
    plc_clock_ctrl #(.TB_WAIT(16'h0008), .LOCKUP_EXTRA(16'h0010)) dut (
        .clk_i, .rst_i, .por_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i,
        .stb_i, .dat_o, .ack_o, .pll_mode_i, .ext_clk_i, .halt_instr_i,
        .wake_i, .osc_en_o, .pll_en_o, .cpu_clk_en_o, .periph_clk_en_o);
    plc_core_model core (.clk_i, .rst_i, .cpu_clk_en_i(cpu_clk_en_o),
        .halt_req_i(halt_req), .halt_instr_o(halt_instr_i));
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e, input string w);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // System reset in mid-run; the lock flag must ride through it
    task automatic sys_reset();
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
    endtask
    task automatic wb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic ens(input logic [3:0] e, input string s);
        #1 chk({osc_en_o, pll_en_o, cpu_clk_en_o, periph_clk_en_o}, e, s);
    endtask
    task automatic wake();
        @(posedge clk_i);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
    endtask
    task automatic poll_lock();
        logic [31:0] q;
        int t0;
        t0 = cyc_cnt;
        // Speed-dependent code must wait for lock before it runs
        do wb(0, plc_pkg::ADR_LOCK, 0, q);
        while (q !== 32'h0 && cyc_cnt - t0 < 200);
        chk(q, 32'h0, "lock settles");
    endtask
    task automatic t_lock();
        logic [31:0] q;
        int t0;
        t0 = cyc_cnt;
        wb(0, plc_pkg::ADR_LOCK, 0, q);
        chk(q, 32'h1, "lock at power on");
        sys_reset();
        wb(0, plc_pkg::ADR_LOCK, 0, q);
        chk(q, 32'h1, "unlocked kept by reset");
        poll_lock();
        chk(32'(cyc_cnt - t0 > TBW), 1, "lockup length");
        wb(1, plc_pkg::ADR_LOCK, 32'hFF, q);
        sys_reset();
        wb(0, plc_pkg::ADR_LOCK, 0, q);
        chk(q, 32'h0, "lock after write and reset");
        wb(0, plc_pkg::ADR_MODE_SEL, 0, q);
        chk(q, 32'(plc_pkg::STOP_SEL_RST), "select after reset");
        wb(0, 32'hFFFF_F840, 0, q);
        chk(q, 32'h0, "unmapped read");
    endtask
    task automatic t_halt();
        @(posedge clk_i);
        halt_req <= 1'b1;
        @(posedge clk_i);
        halt_req <= 1'b0;
        tick(2);
        ens(4'b1101, "halt");
        wake();
        ens(4'b1111, "halt release");
    endtask
    task automatic t_idle();
        logic [31:0] q;
        wb(1, plc_pkg::ADR_MODE_SEL, 0, q);
        wb(1, plc_pkg::ADR_CONTROL, 0, q);
        ens(4'b1111, "standby off");
        wb(1, plc_pkg::ADR_CONTROL, 32'h2, q);
        ens(4'b1100, "idle");
        wake();
        ens(4'b1111, "idle release");
    endtask
    task automatic t_stop(input logic pm, input logic ext);
        logic [31:0] q;
        int n;
        pll_mode_i <= pm;
        // ext_clk_i is set to ext, selecting the external source from here on, until the next t_stop call, when ext is 1
        ext_clk_i <= ext;
        tick(3);
        wb(1, plc_pkg::ADR_MODE_SEL, 32'h1, q);
        wb(1, plc_pkg::ADR_CONTROL, 32'h2, q);
        ens(4'b0000, "stop");
        wb(0, plc_pkg::ADR_LOCK, 0, q);
        chk(q, {31'h0, pm}, "lock on stop");
        wb(0, plc_pkg::ADR_STATUS, 0, q);
        chk(q, 32'h3, "state is stop");
        wb(0, plc_pkg::ADR_CONTROL, 0, q);
        chk(q, 32'h2, "standby read back");
        wake();
        n = 0;
        while (cpu_clk_en_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n >= TBW && n <= TBW + 2), 1, "wake wait");
        ens({!ext, pm, 2'b11}, "after stop");
        poll_lock();
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt > 5000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        tick(20);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        t_lock();
        t_halt();
        t_idle();
        t_stop(1'b1, 1'b0);
        t_stop(1'b1, 1'b1);
        t_stop(1'b0, 1'b1);
        end_sim();
    end
endmodule // tb_plc_clock_ctrl
`default_nettype wire
